//--- bsp_pkg.sv
// What this block does
// - master serial clock period is divide value plus one CPU cycles, two cycles for divide zero
// - low phase is half the period for odd or zero divide, else divide/2
// - high phase is half the period for odd or zero divide, else divide/2+1
// - master inverts its frame-sync output to form an active-low slave enable
// - slave inverts the active-low enable on both frame-sync pins before use
// - master drives enable low first, transfer starts with it, before the first clock edge
// - code 11b, polarity zero: one full period from enable to first rise
// - polarity one: high phase in 10b, full period in 11b before first fall
// - enable held one period (10b) or one idle phase (11b) after last edge
// - 11b/pol0 and 10b/pol1: launch after falling edge, capture on rising
// - 11b with polarity one: launch after rising edge, capture on falling
// - master releases its data output after the last bit: at the final edge in 11b, one idle phase after it in 10b
// - slave releases its data output at its final edge in 11b, when the external enable returns high in 10b
// - slave presents its first bit when the enable falls, before any edge
package bsp_pkg;
  localparam int WORD_BITS = 16;
  localparam int DIV_BITS  = 8;
  localparam int CNT_BITS  = 9;
  localparam int BIT_BITS  = 4;
  localparam int SYNC_BITS = 4;
  // cpu clock period, the unit in which the serial timing is counted
  localparam int CLK_PERIOD_NS = 20;
  localparam int HALF_NS       = CLK_PERIOD_NS / 2;
  localparam int CYCLES_PER_2H = (2 * HALF_NS) / CLK_PERIOD_NS;
  // master captures through the same two-flop path as the slave
  localparam int CAPTURE_DELAY = 2;

  localparam logic [CNT_BITS-1:0] CNT_ONE     = CNT_BITS'(CYCLES_PER_2H);
  localparam logic [CNT_BITS-1:0] CNT_ZERO    = 9'h000;
  localparam logic [BIT_BITS-1:0] BIT_ZERO    = 4'h0;
  localparam logic [BIT_BITS-1:0] BIT_ONE     = 4'h1;
  localparam logic [BIT_BITS-1:0] LAST_BIT    = BIT_BITS'(WORD_BITS - 1);
  localparam logic [DIV_BITS-1:0] SLAVE_DIV   = 8'h01;
  localparam logic [1:0]          STOP_NODLY  = 2'h2;
  localparam logic [1:0]          STOP_HALF   = 2'h3;
  localparam logic [WORD_BITS-1:0] WORD_ZERO = 16'h0000;
  // order: clock, tx sync, rx sync, data; sync pins idle high
  localparam logic [SYNC_BITS-1:0] SYNC_RESET = 4'h6;

  typedef enum logic [3:0] {
    BSP_IDLE  = 4'h1,
    BSP_LEAD  = 4'h2,
    BSP_SHIFT = 4'h4,
    BSP_TRAIL = 4'h8
  } bsp_state_t;
endpackage

//--- bsp_sync.sv
`timescale 1ns/10ps
`default_nettype none
module bsp_sync #(
  parameter int                  WIDTH       = 4,
  parameter logic [WIDTH-1:0]    RESET_VALUE = '0
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // pins in, synchronised out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_q <= RESET_VALUE;
      sync_q <= RESET_VALUE;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

//--- bsp_buf2.sv
`timescale 1ns/10ps
`default_nettype none
module bsp_buf2 #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // filling side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // draining side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  logic [WIDTH-1:0] mem [2];
  logic             wr_q;
  logic             rd_q;
  logic [1:0]       cnt_q;
  logic [1:0]       cnt_d;
  logic             in_ready_q;
  logic             out_valid_q;
  logic             push_w;
  logic             pop_w;

  assign push_w = in_valid & in_ready_q;
  assign pop_w  = out_ready & out_valid_q;
  assign cnt_d  = cnt_q + {1'b0, push_w} - {1'b0, pop_w};

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_q        <= 1'b0;
      rd_q        <= 1'b0;
      cnt_q       <= 2'h0;
      in_ready_q  <= 1'b1;
      out_valid_q <= 1'b0;
    end else begin
      wr_q        <= wr_q ^ push_w;
      rd_q        <= rd_q ^ pop_w;
      cnt_q       <= cnt_d;
      in_ready_q  <= (cnt_d != 2'h2);
      out_valid_q <= (cnt_d != 2'h0);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push_w) begin
      mem[wr_q] <= in_data;
    end
  end

  assign in_ready  = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_data  = mem[rd_q];
endmodule
`default_nettype wire

//--- bsp_spi_clock_stop.sv
`timescale 1ns/10ps
`default_nettype none
module bsp_spi_clock_stop (
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          reset,
  // configuration
  input  wire logic [1:0]                    clock_stop_select,
  input  wire logic                          tx_clock_polarity,
  input  wire logic                          tx_sync_polarity,
  input  wire logic                          rx_sync_polarity,
  input  wire logic [bsp_pkg::DIV_BITS-1:0]  clock_divide_value,
  input  wire logic                          rate_gen_source_select,
  input  wire logic                          tx_clock_mode_select,
  input  wire logic                          tx_sync_mode_select,
  input  wire logic                          rx_clock_mode_select,
  input  wire logic                          rx_sync_mode_select,
  // status clears
  input  wire logic                          overrun_clear,
  input  wire logic                          underrun_clear,
  // transmit words
  input  wire logic [bsp_pkg::WORD_BITS-1:0] tx_data,
  input  wire logic                          tx_valid,
  output logic                               tx_ready,
  // receive words
  output logic      [bsp_pkg::WORD_BITS-1:0] rx_data,
  output logic                               rx_valid,
  input  wire logic                          rx_ready,
  // status
  output logic                               busy,
  output logic                               rx_overrun,
  output logic                               tx_underrun,
  output logic                               config_error,
  // serial pins
  input  wire logic                          serial_tx_clock_pin_i,
  output logic                               serial_tx_clock_pin_o,
  output logic                               serial_tx_clock_pin_oe,
  input  wire logic                          tx_frame_sync_pin_i,
  output logic                               tx_frame_sync_pin_o,
  output logic                               tx_frame_sync_pin_oe,
  input  wire logic                          rx_frame_sync_pin_i,
  input  wire logic                          serial_rx_data_pin_i,
  output logic                               serial_tx_data_pin_o,
  output logic                               serial_tx_data_pin_oe
);
  localparam int W = bsp_pkg::WORD_BITS;
  localparam int CB = bsp_pkg::CNT_BITS;

  // pin synchronisers
  logic [bsp_pkg::SYNC_BITS-1:0] pin_raw_w;
  logic [bsp_pkg::SYNC_BITS-1:0] pin_sync_w;
  logic                          sclk_s;
  logic                          txfs_s;
  logic                          rxfs_s;
  logic                          din_s;

  assign pin_raw_w = {serial_tx_clock_pin_i, tx_frame_sync_pin_i,
                      rx_frame_sync_pin_i, serial_rx_data_pin_i};

  bsp_sync #(
    .WIDTH       (bsp_pkg::SYNC_BITS),
    .RESET_VALUE (bsp_pkg::SYNC_RESET)
  ) u_sync (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .async_in (pin_raw_w),
    .sync_out (pin_sync_w)
  );

  assign sclk_s = pin_sync_w[3];
  assign txfs_s = pin_sync_w[2];
  assign rxfs_s = pin_sync_w[1];
  assign din_s  = pin_sync_w[0];

  // word buffers
  logic [W-1:0] tx_word_w;
  logic         tx_word_valid_w;
  logic         tx_pop_w;
  logic [W-1:0] rx_word_w;
  logic         rx_push_w;
  logic         rx_room_w;

  bsp_buf2 #(.WIDTH(W)) u_tx_buf (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (tx_word_w),
    .out_valid (tx_word_valid_w),
    .out_ready (tx_pop_w)
  );

  bsp_buf2 #(.WIDTH(W)) u_rx_buf (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_data   (rx_word_w),
    .in_valid  (rx_push_w),
    .in_ready  (rx_room_w),
    .out_data  (rx_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  // mode decode
  logic master_w;
  logic spi_on_w;
  logic delay_w;
  logic config_bad_w;

  assign master_w = tx_clock_mode_select & tx_sync_mode_select;
  assign spi_on_w = (clock_stop_select == bsp_pkg::STOP_NODLY) | delay_w;
  assign delay_w  = (clock_stop_select == bsp_pkg::STOP_HALF);
  assign config_bad_w = master_w ? (rx_clock_mode_select | rx_sync_mode_select)
                      : (tx_clock_mode_select | tx_sync_mode_select |
                         rx_clock_mode_select | rx_sync_mode_select |
                         ~rate_gen_source_select |
                         (clock_divide_value != bsp_pkg::SLAVE_DIV));

  // clock phase lengths in cpu cycles
  logic [CB-1:0] period_w;
  logic [CB-1:0] low_raw_w;
  logic [CB-1:0] low_w;
  logic [CB-1:0] high_w;
  logic [CB-1:0] full_w;
  logic [CB-1:0] idle_ph_w;
  logic [CB-1:0] next_ph_w;
  logic [CB-1:0] lead_w;
  logic [CB-1:0] trail_w;
  logic [CB-1:0] release_at_w;

  assign period_w  = {1'b0, clock_divide_value} + bsp_pkg::CNT_ONE;
  assign low_raw_w = period_w >> 1;
  // divide zero would need half-cycle phases, so it runs as one cycle each
  assign low_w     = (low_raw_w == bsp_pkg::CNT_ZERO) ? bsp_pkg::CNT_ONE : low_raw_w;
  assign high_w    = (low_raw_w == bsp_pkg::CNT_ZERO) ? bsp_pkg::CNT_ONE
                   : period_w - low_raw_w;
  assign full_w    = low_w + high_w;
  assign idle_ph_w = tx_clock_polarity ? high_w : low_w;
  assign lead_w    = delay_w ? full_w : idle_ph_w;
  assign trail_w   = delay_w ? idle_ph_w : full_w;
  assign release_at_w = trail_w - idle_ph_w;

  // master sequencer
  bsp_pkg::bsp_state_t state_q;
  bsp_pkg::bsp_state_t state_d;
  logic [CB-1:0]       cnt_q;
  logic [CB-1:0]       cnt_d;
  logic                half_q;
  logic                half_d;
  logic                sclk_q;
  logic                sclk_d;
  logic                fs_pin_q;
  logic                fs_pin_d;
  logic                drive_q;

  // shared bit engine
  logic                  active_q;
  logic [bsp_pkg::BIT_BITS-1:0] tbit_q;
  logic [bsp_pkg::BIT_BITS-1:0] rbit_q;
  logic [W-1:0]          tx_sh_q;
  logic [W-1:0]          rx_sh_q;
  logic                  oe_q;
  logic [bsp_pkg::CAPTURE_DELAY-1:0] cap_dly_q;
  logic                  sclk_prev_q;
  logic                  en_prev_q;
  logic                  overrun_q;
  logic                  underrun_q;
  logic                  config_err_q;

  logic cnt_zero_w;
  logic m_toggle_w;
  logic m_e1_w;
  logic m_e2_w;
  logic m_start_w;
  logic slave_en_w;
  logic c_now_w;
  logic c_prev_w;
  logic s_e1_w;
  logic s_e2_w;
  logic s_start_w;
  logic s_stop_w;
  logic ev_e1_w;
  logic ev_e2_w;
  logic last_bit_w;
  logic launch_w;
  logic cap_now_w;
  logic cap_w;
  logic rel_w;
  logic start_w;

  assign next_ph_w  = sclk_q ? low_w : high_w;
  assign cnt_zero_w = (cnt_q == bsp_pkg::CNT_ZERO);
  assign m_toggle_w = cnt_zero_w & ((state_q == bsp_pkg::BSP_LEAD) |
                                    (state_q == bsp_pkg::BSP_SHIFT));
  assign m_e1_w     = m_toggle_w & ((state_q == bsp_pkg::BSP_LEAD) | ~half_q);
  assign m_e2_w     = m_toggle_w & (state_q == bsp_pkg::BSP_SHIFT) & half_q;
  // no new master transfer while the receive buffer has no room for its word
  assign m_start_w  = (state_q == bsp_pkg::BSP_IDLE) & spi_on_w & master_w &
                      tx_word_valid_w & rx_room_w;

  assign slave_en_w = (txfs_s ^ tx_sync_polarity) & (rxfs_s ^ rx_sync_polarity);
  assign c_now_w    = sclk_s ^ tx_clock_polarity;
  assign c_prev_w   = sclk_prev_q ^ tx_clock_polarity;
  assign s_e1_w     = c_now_w & ~c_prev_w & slave_en_w & active_q;
  assign s_e2_w     = ~c_now_w & c_prev_w & slave_en_w & active_q;
  assign s_start_w  = ~master_w & spi_on_w & slave_en_w & ~en_prev_q;
  assign s_stop_w   = ~master_w & active_q & ~slave_en_w;

  assign start_w    = m_start_w | s_start_w;
  assign tx_pop_w   = m_start_w | (s_start_w & tx_word_valid_w);
  assign ev_e1_w    = master_w ? m_e1_w : s_e1_w;
  assign ev_e2_w    = master_w ? m_e2_w : s_e2_w;
  assign last_bit_w = (tbit_q == bsp_pkg::LAST_BIT);
  assign launch_w   = delay_w ? (ev_e2_w & ~last_bit_w)
                    : (ev_e1_w & (tbit_q != bsp_pkg::BIT_ZERO));
  assign cap_now_w  = delay_w ? ev_e1_w : ev_e2_w;
  assign cap_w      = master_w ? cap_dly_q[bsp_pkg::CAPTURE_DELAY-1] : cap_now_w;
  assign rx_word_w  = {rx_sh_q[W-2:0], din_s};
  assign rx_push_w  = cap_w & (rbit_q == bsp_pkg::LAST_BIT);
  assign rel_w      = (delay_w & ev_e2_w & last_bit_w) |
                      (master_w & ~delay_w & (state_q == bsp_pkg::BSP_TRAIL) &
                       (cnt_q == release_at_w)) |
                      s_stop_w;

  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    half_d   = half_q;
    sclk_d   = sclk_q;
    fs_pin_d = fs_pin_q;
    unique case (state_q)
      bsp_pkg::BSP_IDLE: begin
        sclk_d   = tx_clock_polarity;
        fs_pin_d = tx_sync_polarity;
        if (m_start_w) begin
          fs_pin_d = ~tx_sync_polarity;
          cnt_d    = lead_w - bsp_pkg::CNT_ONE;
          state_d  = bsp_pkg::BSP_LEAD;
        end
      end
      bsp_pkg::BSP_LEAD: begin
        if (cnt_zero_w) begin
          sclk_d  = ~sclk_q;
          cnt_d   = next_ph_w - bsp_pkg::CNT_ONE;
          half_d  = 1'b1;
          state_d = bsp_pkg::BSP_SHIFT;
        end else begin
          cnt_d = cnt_q - bsp_pkg::CNT_ONE;
        end
      end
      bsp_pkg::BSP_SHIFT: begin
        if (cnt_zero_w) begin
          sclk_d = ~sclk_q;
          half_d = ~half_q;
          if (half_q && last_bit_w) begin
            cnt_d   = trail_w - bsp_pkg::CNT_ONE;
            state_d = bsp_pkg::BSP_TRAIL;
          end else begin
            cnt_d = next_ph_w - bsp_pkg::CNT_ONE;
          end
        end else begin
          cnt_d = cnt_q - bsp_pkg::CNT_ONE;
        end
      end
      bsp_pkg::BSP_TRAIL: begin
        if (cnt_zero_w) begin
          fs_pin_d = tx_sync_polarity;
          state_d  = bsp_pkg::BSP_IDLE;
        end else begin
          cnt_d = cnt_q - bsp_pkg::CNT_ONE;
        end
      end
      default: begin
        state_d = bsp_pkg::BSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q  <= bsp_pkg::BSP_IDLE;
      cnt_q    <= bsp_pkg::CNT_ZERO;
      half_q   <= 1'b0;
      sclk_q   <= 1'b0;
      fs_pin_q <= 1'b1;
      drive_q  <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      half_q   <= half_d;
      sclk_q   <= sclk_d;
      fs_pin_q <= fs_pin_d;
      drive_q  <= spi_on_w & master_w;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      active_q <= 1'b0;
      oe_q     <= 1'b0;
    end else begin
      active_q <= start_w | (active_q & ~s_stop_w &
                  ~(master_w & (state_q == bsp_pkg::BSP_TRAIL) & cnt_zero_w));
      oe_q     <= start_w | (oe_q & ~rel_w);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tbit_q    <= bsp_pkg::BIT_ZERO;
      rbit_q    <= bsp_pkg::BIT_ZERO;
      tx_sh_q   <= bsp_pkg::WORD_ZERO;
      rx_sh_q   <= bsp_pkg::WORD_ZERO;
      cap_dly_q <= '0;
    end else begin
      cap_dly_q <= {cap_dly_q[bsp_pkg::CAPTURE_DELAY-2:0], cap_now_w & master_w};
      if (start_w) begin
        tbit_q  <= bsp_pkg::BIT_ZERO;
        rbit_q  <= bsp_pkg::BIT_ZERO;
        // slave shows bit one as soon as the enable falls
        tx_sh_q <= tx_word_valid_w ? tx_word_w : bsp_pkg::WORD_ZERO;
      end else begin
        if (ev_e2_w) begin
          tbit_q <= tbit_q + bsp_pkg::BIT_ONE;
        end
        if (launch_w) begin
          tx_sh_q <= {tx_sh_q[W-2:0], 1'b0};
        end
        if (cap_w) begin
          rx_sh_q <= rx_word_w;
          rbit_q  <= rbit_q + bsp_pkg::BIT_ONE;
        end
      end
    end
  end

  // set beats a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sclk_prev_q  <= 1'b0;
      en_prev_q    <= 1'b0;
      overrun_q    <= 1'b0;
      underrun_q   <= 1'b0;
      config_err_q <= 1'b0;
    end else begin
      sclk_prev_q  <= sclk_s;
      en_prev_q    <= slave_en_w;
      overrun_q    <= (rx_push_w & ~rx_room_w) | (overrun_q & ~overrun_clear);
      underrun_q   <= (s_start_w & ~tx_word_valid_w) | (underrun_q & ~underrun_clear);
      config_err_q <= spi_on_w & config_bad_w;
    end
  end

  assign serial_tx_clock_pin_o  = sclk_q;
  assign serial_tx_clock_pin_oe = drive_q;
  assign tx_frame_sync_pin_o    = fs_pin_q;
  assign tx_frame_sync_pin_oe   = drive_q;
  assign serial_tx_data_pin_o   = tx_sh_q[W-1];
  assign serial_tx_data_pin_oe  = oe_q;
  assign busy                   = active_q;
  assign rx_overrun             = overrun_q;
  assign tx_underrun            = underrun_q;
  assign config_error           = config_err_q;
endmodule
`default_nettype wire

//--- bsp_spi_clock_stop_checker.sv
`timescale 1ns/10ps
`default_nettype none
module bsp_spi_clock_stop_checker (
  // clock and reset
  input wire logic                         sys_clk,
  input wire logic                         reset,
  // configuration
  input wire logic [1:0]                   clock_stop_select,
  input wire logic                         tx_clock_polarity,
  input wire logic [bsp_pkg::DIV_BITS-1:0] clock_divide_value,
  input wire logic                         tx_clock_mode_select,
  input wire logic                         tx_sync_mode_select,
  // status and pins
  input wire logic                         busy,
  input wire logic                         serial_tx_clock_pin_o,
  input wire logic                         tx_frame_sync_pin_o,
  input wire logic                         tx_frame_sync_pin_i,
  input wire logic                         rx_frame_sync_pin_i,
  input wire logic                         serial_tx_data_pin_oe
);
  logic       clk_q;
  logic [1:0] cfg_q;
  logic [8:0] run_q;
  wire        pol = tx_clock_polarity;
  wire        mst = clock_stop_select[1] & tx_clock_mode_select & tx_sync_mode_select;
  wire        slv = clock_stop_select[1] & ~mst;
  wire        half = clock_stop_select[0];
  wire        edg = serial_tx_clock_pin_o != clk_q;
  wire        div3 = clock_divide_value == 8'h03;
  wire [8:0]  per = (clock_divide_value == 8'h00) ? 9'h002 : {1'b0, clock_divide_value} + 9'h001;
  wire [8:0]  lo = per >> 1;
  // config changes take a cycle to reach the pins, so skip that cycle
  wire        steady = cfg_q == {mst, pol};

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // run_q: cycles the clock pin held its level before this sample
  always_ff @(posedge sys_clk) begin
    clk_q <= serial_tx_clock_pin_o;
    run_q <= (reset | edg) ? 9'h001 : run_q + 9'h001;
    cfg_q <= {mst, pol};
  end

  sequence s_lead2;
    (serial_tx_clock_pin_o == pol) [*2] ##1 (serial_tx_clock_pin_o != pol);
  endsequence
  sequence s_lead4;
    (serial_tx_clock_pin_o == pol) [*4] ##1 (serial_tx_clock_pin_o != pol);
  endsequence

  a_idle_park: assert property (mst && steady && !busy && !$past(busy) && !$past(reset)
    |-> serial_tx_clock_pin_o == pol) else $error("clock not parked at idle level");
  a_active_phase: assert property (mst && steady && busy && edg && serial_tx_clock_pin_o == pol
    |-> run_q == (pol ? lo : per - lo)) else $error("active clock phase length wrong");
  a_start_enable: assert property (mst && steady && $fell(tx_frame_sync_pin_o)
    |-> busy && serial_tx_data_pin_oe && serial_tx_clock_pin_o == pol)
    else $error("enable asserted without driven data or with clock moved");
  a_lead_short: assert property (mst && steady && div3 && !half && $fell(tx_frame_sync_pin_o)
    |-> s_lead2) else $error("no-delay lead to first edge wrong");
  a_lead_full: assert property (mst && steady && div3 && half && $fell(tx_frame_sync_pin_o)
    |-> s_lead4) else $error("half-delay lead to first edge wrong");
  a_trail_hold: assert property (mst && steady && div3 && $rose(tx_frame_sync_pin_o)
    |-> !edg && run_q == (half ? 9'h002 : 9'h004)) else $error("enable trail length wrong");
  a_oe_release: assert property (mst && steady && div3 && busy && $fell(serial_tx_data_pin_oe)
    |-> (half ? edg : (!edg && run_q == 9'h002))) else $error("data release timing wrong");
  a_slave_answer: assert property (slv && steady && $fell(tx_frame_sync_pin_i) && !rx_frame_sync_pin_i
    |-> ##[1:5] serial_tx_data_pin_oe) else $error("slave did not drive data after enable");
  a_slave_release: assert property ((slv && tx_frame_sync_pin_i && rx_frame_sync_pin_i) [*5]
    |-> !serial_tx_data_pin_oe) else $error("slave drives data while deselected");
endmodule
bind bsp_spi_clock_stop bsp_spi_clock_stop_checker i_chk (.*);
`default_nettype wire

//--- bsp_spi_partner.sv
`timescale 1ns/10ps
`default_nettype none
module bsp_spi_partner (
  // serial pins
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  output logic             miso,
  // mode and words
  input  wire logic        half_delay,
  input  wire logic [15:0] reply,
  output logic [15:0]      heard
);
  int          edge_n = 0;
  logic [15:0] out_q;
  initial miso = 1'b0;
  // deselected: flip the line so a stale bit never reads as good
  always @(posedge cs_n) miso = ~miso;
  always @(negedge cs_n) begin
    edge_n = 0;
    out_q = reply;
    miso = out_q[15];
  end
  always @(sclk) begin
    if (!cs_n) begin
      if (half_delay ^ edge_n[0]) heard = {heard[14:0], mosi};
      else if (edge_n > 0) begin
        out_q = out_q << 1;
        miso = out_q[15];
      end
      edge_n++;
    end
  end
endmodule
`default_nettype wire

//--- bsp_spi_clock_stop_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s expected %h seen %h", n, e, g); end end
`define WAIT(c) begin int k; k = 0; do begin @(posedge sys_clk); k++; end \
  while ((c) !== 1'b1 && k < 3000); if (k >= 3000) begin num_errors++; conclude(); end end
module bsp_spi_clock_stop_tb;
  logic        sys_clk = 1'b0, reset = 1'b1, tx_clock_polarity = 1'b0, tx_valid = 1'b0;
  logic [1:0]  clock_stop_select = 2'h2;
  logic [7:0]  clock_divide_value = 8'h03;
  logic        tx_sync_polarity = 1'b1, rx_sync_polarity = 1'b1, rate_gen_source_select = 1'b1;
  logic        tx_clock_mode_select = 1'b1, tx_sync_mode_select = 1'b1, rx_ready = 1'b0;
  logic        rx_clock_mode_select = 1'b0, rx_sync_mode_select = 1'b0, underrun_clear = 1'b0;
  logic        overrun_clear = 1'b0, s_clk = 1'b0, s_cs = 1'b1, s_din = 1'b0, miso;
  logic [15:0] tx_data = 16'h0000, reply = 16'h0000, rx_data, heard;
  logic        tx_ready, rx_valid, busy, rx_overrun, tx_underrun, config_error;
  logic        serial_tx_clock_pin_o, serial_tx_clock_pin_oe, tx_frame_sync_pin_o;
  logic        tx_frame_sync_pin_oe, serial_tx_data_pin_o, serial_tx_data_pin_oe;
  int          num_errors = 0, tests_run = 0, edges = 0, i;
  wire logic   serial_tx_clock_pin_i = serial_tx_clock_pin_oe ? serial_tx_clock_pin_o : s_clk;
  wire logic   tx_frame_sync_pin_i = tx_frame_sync_pin_oe ? tx_frame_sync_pin_o : s_cs;
  wire logic   rx_frame_sync_pin_i = s_cs;
  wire logic   serial_rx_data_pin_i = tx_clock_mode_select ? miso : s_din;
  wire logic   mosi = serial_tx_data_pin_oe ? serial_tx_data_pin_o : ~serial_tx_data_pin_o;

  always #(bsp_pkg::HALF_NS) sys_clk = ~sys_clk;
  always @(serial_tx_clock_pin_o) edges++;

  bsp_spi_clock_stop i_dut (.*);
  bsp_spi_partner i_peer (.sclk(serial_tx_clock_pin_i), .cs_n(tx_frame_sync_pin_i),
    .mosi(mosi), .miso(miso), .half_delay(clock_stop_select[0]), .reply(reply), .heard(heard));

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic mset(logic [1:0] c, logic p, logic [7:0] d, logic m);
    clock_stop_select <= c;
    tx_clock_polarity <= p;
    clock_divide_value <= d;
    tx_clock_mode_select <= m;
    tx_sync_mode_select <= m;
    s_clk <= p;
    tick(3);
  endtask
  task automatic push(logic [15:0] w);
    tx_data <= w;
    tx_valid <= 1'b1;
    `WAIT(tx_ready)
    tx_valid <= 1'b0;
    tick(1);
  endtask
  task automatic pop(logic [15:0] e);
    `WAIT(rx_valid)
    `CHK("rx_data", e, rx_data)
    rx_ready <= 1'b1;
    tick(1);
    rx_ready <= 1'b0;
    tick(1);
  endtask
  task automatic mxfer(logic [1:0] c, logic p, logic [7:0] d, logic [15:0] w, r);
    mset(c, p, d, 1'b1);
    reply <= r;
    edges = 0;
    push(w);
    `WAIT(busy)
    `WAIT(!busy)
    `CHK("edge count", 32, edges)
    `CHK("peer heard", w, heard)
    pop(r);
    $display("test master %h %0d %0d done", c, p, d);
  endtask
  // slave side: tb plays the far master, six-cycle phases clear the input sync
  task automatic sxfer(logic [1:0] c, logic p, logic f, logic [15:0] w, o);
    int b;
    logic [15:0] got;
    mset(c, p, 8'h01, 1'b0);
    if (f) push(o);
    s_cs <= 1'b0;
    s_din <= w[15];
    tick(8);
    `CHK("slave first bit", o[15], serial_tx_data_pin_o)
    for (b = 0; b < 32; b++) begin
      if (c[0] ^ b[0]) got = {got[14:0], serial_tx_data_pin_o};
      else if (b > 0 && b < 31) s_din <= w[15 - (b + 1) / 2];
      s_clk <= ~s_clk;
      tick(6);
    end
    s_cs <= 1'b1;
    s_din <= ~s_din;
    tick(8);
    `CHK("slave release", 1'b0, serial_tx_data_pin_oe)
    `CHK("slave sent", o, got)
    pop(w);
    $display("test slave %h %0d done", c, p);
  endtask

  initial begin
    tick(20);
    reset <= 1'b0;
    tick(2);
    `CHK("idle enable", 1'b1, tx_frame_sync_pin_o)
    `CHK("idle data oe", 1'b0, serial_tx_data_pin_oe)
    for (i = 0; i < 4; i++) mxfer(2'h2 | 2'(i >> 1), i[0], 8'h03, 16'hC3A5 + 16'(i), 16'h0F1E);
    mxfer(2'h2, 1'b0, 8'h04, 16'h8001, 16'h7FFE);
    mxfer(2'h3, 1'b1, 8'h04, 16'h00FF, 16'hFF00);
    mxfer(2'h3, 1'b0, 8'h00, 16'hF00F, 16'h1234);
    mxfer(2'h2, 1'b1, 8'h05, 16'h5555, 16'hAAAA);
    mset(2'h2, 1'b0, 8'h03, 1'b1);
    reply <= 16'h3C5A;
    push(16'h1111);
    push(16'h2222);
    push(16'h3333);
    push(16'h4444);
    tick(400);
    `CHK("stalled start", 1'b0, busy)
    `CHK("tx buffer full", 1'b0, tx_ready)
    for (i = 0; i < 4; i++) pop(16'h3C5A);
    `WAIT(!busy)
    `CHK("last heard", 16'h4444, heard)
    `CHK("no overrun", 1'b0, rx_overrun)
    $display("test buffers done");
    for (i = 0; i < 4; i++) sxfer(2'h2 | 2'(i >> 1), i[0], 1'b1, 16'h9A6B + 16'(i), 16'h2D4E);
    sxfer(2'h3, 1'b0, 1'b0, 16'h6C39, 16'h0000);
    `CHK("underrun", 1'b1, tx_underrun)
    underrun_clear <= 1'b1;
    tick(2);
    underrun_clear <= 1'b0;
    tick(2);
    `CHK("underrun clear", 1'b0, tx_underrun)
    `CHK("slave pins", 2'h0, {serial_tx_clock_pin_oe, tx_frame_sync_pin_oe})
    mset(2'h2, 1'b0, 8'h03, 1'b1);
    rx_clock_mode_select <= 1'b1;
    tick(4);
    `CHK("config error", 1'b1, config_error)
    rx_clock_mode_select <= 1'b0;
    tick(4);
    `CHK("config ok", 1'b0, config_error)
    `CHK("pin drive", 2'h3, {serial_tx_clock_pin_oe, tx_frame_sync_pin_oe})
    clock_stop_select <= 2'h0;
    tick(2);
    `CHK("port off", 2'h0, {serial_tx_clock_pin_oe, tx_frame_sync_pin_oe})
    $display("test status done");
    conclude();
  end
endmodule
`default_nettype wire
